/* File: rtl/scs_startup_config.v */
// Functional notes
// - device wakes in full power-down and stays there until programmed over serial port.
// - gain value 0x06 means LNA 21.6 dB, external VGA, postamp 24 dB.
// - profile bytes 0xFF, 0x7F select continuous run, no channel power-down.
// - third byte 0x00 powers channels at trigger; fourth bit 7 bypasses HPF.
// - wake-up from power-down to run takes 375 us.
// - output-format value 0x00 selects default data format.
// - serial output value 0x05 means 14-bit, 8 lanes, frame clock whole frame.
// - clocks-per-sample bit 7 enables automatic clock count.
// - writing 0x20 to 0x10C raises software trigger, running the digital block.
// - low-pass value 0x18 sets default cutoff and bandwidth.
// - filter tune (0x40 to 0x02B) takes 512 ADC clocks.
// - setup register mirrors bit order bits 6/1, reset 5/2; bits 4,3 one; 0x18.
`include "scs_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module scs_startup_config #(
    parameter WAKE_CYC = `SCS_WAKE_CYC
) (
    input wire i_clk_sys,
    input wire i_rst,
    input wire i_sclk,
    input wire i_csb_n,
    input wire i_sdio,
    input wire i_transmit_trigger,
    input wire i_adc_clk,
    output reg o_sdio,
    output reg o_sdio_oe,
    output reg o_power_down,
    output reg o_running,
    output reg o_ready,
    output reg o_tune_busy,
    output reg o_lsb_first,
    output reg o_hpf_bypass,
    output reg o_cps_auto,
    output reg o_continuous_run,
    output reg [7:0] o_gain,
    output reg [7:0] o_serial_out,
    output reg [7:0] o_lpf
);
////////////////////////////////////////////////////////////////////////////////
    wire sclk_s, csb_s, sdio_s, trig_s, adc_s;
    scs_sync u_s0 (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_async(i_sclk), .o_sync(sclk_s));
    scs_sync u_s1 (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_async(i_csb_n), .o_sync(csb_s));
    scs_sync u_s2 (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_async(i_sdio), .o_sync(sdio_s));
    scs_sync u_s3 (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_async(i_transmit_trigger),
        .o_sync(trig_s));
    scs_sync u_s4 (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_async(i_adc_clk), .o_sync(adc_s));

    reg sclk_d, adc_d, trig_d;
    wire sclk_rise = sclk_s & ~sclk_d;
    wire sclk_fall = ~sclk_s & sclk_d;
    wire adc_rise = adc_s & ~adc_d;
    wire hw_trig = trig_s & ~trig_d;

////////////////////////////////////////////////////////////////////////////////
    // serial frame: 16-bit instruction (rw, w1, w0, addr[12:0]) then data bytes
    reg [4:0] bitcnt;
    reg [15:0] shreg;
    reg in_data, rd;
    reg [12:0] addr;
    reg [7:0] rdbyte;
    wire [15:0] next_shreg = {shreg[14:0], sdio_s};

    reg [7:0] setup, grade, idx2, idx1, modes, lpf_r, gain, fmt, ser, decim, cps;
    reg [7:0] prof [0:3];
    reg grade_written, armed_extra, profile_taken;
    reg [16:0] wake_cnt;
    reg [9:0] tune_cnt;

    wire lsb_first = setup[`SCS_SETUP_LSB_HI] | setup[`SCS_SETUP_LSB_LO];
    // lsb-first frames arrive reversed; the mirrored setup layout makes 0x000 immune
    wire [7:0] rx_byte;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_rev
            assign rx_byte[g] = lsb_first ? next_shreg[7 - g] : next_shreg[g];
        end
    endgenerate
    wire byte_done = sclk_rise && !csb_s && in_data && bitcnt == 5'd7;
    wire wr_stb = byte_done && !rd;

    function [7:0] rd_mux;
        input [12:0] a;
        begin
            case (a)
                `SCS_ADDR_SETUP: rd_mux = setup | `SCS_SETUP_ONES;
                `SCS_ADDR_GRADE: rd_mux = grade;
                `SCS_ADDR_IDX2: rd_mux = idx2;
                `SCS_ADDR_IDX1: rd_mux = idx1;
                `SCS_ADDR_MODES: rd_mux = modes;
                `SCS_ADDR_LPF: rd_mux = lpf_r;
                `SCS_ADDR_GAIN: rd_mux = gain;
                `SCS_ADDR_FMT: rd_mux = fmt;
                `SCS_ADDR_SER: rd_mux = ser;
                `SCS_ADDR_DECIM: rd_mux = decim;
                `SCS_ADDR_CPS: rd_mux = cps;
                `SCS_ADDR_PROF0: rd_mux = prof[0];
                `SCS_ADDR_PROF1: rd_mux = prof[1];
                `SCS_ADDR_PROF2: rd_mux = prof[2];
                `SCS_ADDR_PROF3: rd_mux = prof[3];
                default: rd_mux = 8'h00;
            endcase
        end
    endfunction

    always @(posedge i_clk_sys) begin
        if (i_rst || csb_s) begin
            // chip select high aborts any partial byte
            bitcnt <= 5'h00;
            in_data <= 1'b0;
            rd <= 1'b0;
            addr <= 13'h0000;
            shreg <= 16'h0000;
            o_sdio_oe <= 1'b0;
            o_sdio <= 1'b0;
            rdbyte <= 8'h00;
        end else begin
            if (sclk_rise) begin
                shreg <= next_shreg;
                if (!in_data && bitcnt == 5'd15) begin
                    in_data <= 1'b1;
                    bitcnt <= 5'h00;
                    rd <= next_shreg[15];
                    addr <= next_shreg[12:0];
                    rdbyte <= rd_mux(next_shreg[12:0]);
                end else if (in_data && bitcnt == 5'd7) begin
                    bitcnt <= 5'h00;
                    // streaming: address steps down for msb-first, up for lsb-first
                    addr <= lsb_first ? addr + 13'h0001 : addr - 13'h0001;
                    rdbyte <= rd_mux(lsb_first ? addr + 13'h0001 : addr - 13'h0001);
                end else begin
                    bitcnt <= bitcnt + 5'h01;
                end
            end
            if (sclk_fall && in_data && rd) begin
                o_sdio_oe <= 1'b1;
                o_sdio <= lsb_first ? rdbyte[bitcnt[2:0]] : rdbyte[3'd7 - bitcnt[2:0]];
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
    wire srst_req = wr_stb && addr == `SCS_ADDR_SETUP &&
        (rx_byte[`SCS_SETUP_SRST_HI] | rx_byte[`SCS_SETUP_SRST_LO]);
    // a 0x0FF write restores defaults only once speed mode was written since the last reset or update
    wire upd_req = wr_stb && addr == `SCS_ADDR_UPDATE && grade_written;
    wire trig_req = wr_stb && addr == `SCS_ADDR_TRIG;

    integer k;
    always @(posedge i_clk_sys) begin
        adc_d <= adc_s;
        sclk_d <= sclk_s;
        trig_d <= trig_s;
        if (i_rst || srst_req || upd_req) begin
            if (i_rst || srst_req) begin
                grade <= `SCS_RST_GRADE;
            end
            if (i_rst) begin
                setup <= `SCS_RST_SETUP;
            end else if (srst_req) begin
                // reset bits self-clear; bit order is kept as written
                setup <= rx_byte & 8'h42;
            end
            idx2 <= `SCS_RST_IDX2;
            idx1 <= `SCS_RST_IDX1;
            modes <= `SCS_RST_MODES;
            lpf_r <= `SCS_RST_LPF;
            gain <= `SCS_RST_GAIN;
            fmt <= `SCS_RST_FMT;
            ser <= `SCS_RST_SER;
            decim <= `SCS_RST_ZERO;
            cps <= `SCS_RST_ZERO;
            for (k = 0; k < 4; k = k + 1) begin
                prof[k] <= `SCS_RST_ZERO;
            end
            grade_written <= 1'b0;
            armed_extra <= 1'b0;
            profile_taken <= 1'b0;
            wake_cnt <= 17'h00000;
            tune_cnt <= 10'h000;
            o_running <= 1'b0;
            o_ready <= 1'b0;
        end else begin
            if (wr_stb) begin
                case (addr)
                    `SCS_ADDR_SETUP: setup <= rx_byte & 8'h42;
                    `SCS_ADDR_GRADE: begin
                        grade <= rx_byte;
                        grade_written <= 1'b1;
                    end
                    `SCS_ADDR_IDX2: idx2 <= rx_byte;
                    `SCS_ADDR_IDX1: idx1 <= rx_byte;
                    `SCS_ADDR_MODES: modes <= rx_byte;
                    `SCS_ADDR_LPF: lpf_r <= rx_byte;
                    `SCS_ADDR_GAIN: gain <= rx_byte;
                    `SCS_ADDR_FMT: fmt <= rx_byte;
                    `SCS_ADDR_SER: ser <= rx_byte;
                    `SCS_ADDR_DECIM: decim <= rx_byte;
                    `SCS_ADDR_CPS: cps <= rx_byte;
                    `SCS_ADDR_PROF0: prof[0] <= rx_byte;
                    `SCS_ADDR_PROF1: prof[1] <= rx_byte;
                    `SCS_ADDR_PROF2: prof[2] <= rx_byte;
                    `SCS_ADDR_PROF3: prof[3] <= rx_byte;
                    default: ;
                endcase
            end
            // a 0x10C write arms; next msb-first write completes the buffer update
            if (trig_req) begin
                armed_extra <= 1'b1;
            end else if (wr_stb && armed_extra && !lsb_first) begin
                armed_extra <= 1'b0;
                profile_taken <= 1'b1;
            end
            if ((trig_req && rx_byte[`SCS_TRIG_BIT]) || hw_trig) begin
                o_running <= 1'b1;
            end
            if (modes[`SCS_MODE_FIELD] != `SCS_MODE_RUN) begin
                wake_cnt <= 17'h00000;
                o_ready <= 1'b0;
            end else if (wake_cnt == WAKE_CYC[16:0] - 17'h00001) begin
                o_ready <= 1'b1;
            end else begin
                wake_cnt <= wake_cnt + 17'h00001;
            end
            if (wr_stb && addr == `SCS_ADDR_TUNE && rx_byte[`SCS_TUNE_BIT]) begin
                tune_cnt <= `SCS_TUNE_ADC_CYC;
            end else if (adc_rise && tune_cnt != 10'h000) begin
                tune_cnt <= tune_cnt - 10'h001;
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_power_down <= 1'b1;
            o_tune_busy <= 1'b0;
            o_lsb_first <= 1'b0;
            o_hpf_bypass <= 1'b0;
            o_cps_auto <= 1'b0;
            o_continuous_run <= 1'b0;
            o_gain <= `SCS_RST_GAIN;
            o_serial_out <= `SCS_RST_SER;
            o_lpf <= `SCS_RST_LPF;
        end else begin
            o_power_down <= modes[`SCS_MODE_FIELD] != `SCS_MODE_RUN;
            o_tune_busy <= tune_cnt != 10'h000;
            o_lsb_first <= lsb_first;
            o_hpf_bypass <= profile_taken & prof[3][`SCS_HPF_BYP_BIT];
            // 0xFF/0x7F stop timing means the channels never time out
            o_continuous_run <= profile_taken && prof[0] == 8'hFF && prof[1] == 8'h7F;
            o_cps_auto <= cps[`SCS_CPS_AUTO_BIT];
            o_gain <= gain;
            o_serial_out <= ser;
            o_lpf <= lpf_r;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/scs_regs.vh */
`ifndef SCS_REGS_VH
`define SCS_REGS_VH

`define SCS_ADDR_SETUP 13'h0000
`define SCS_ADDR_GRADE 13'h0002
`define SCS_ADDR_IDX2 13'h0004
`define SCS_ADDR_IDX1 13'h0005
`define SCS_ADDR_MODES 13'h0008
`define SCS_ADDR_LPF 13'h000F
`define SCS_ADDR_GAIN 13'h0011
`define SCS_ADDR_FMT 13'h0014
`define SCS_ADDR_SER 13'h0021
`define SCS_ADDR_TUNE 13'h002B
`define SCS_ADDR_UPDATE 13'h00FF
`define SCS_ADDR_TRIG 13'h010C
`define SCS_ADDR_DECIM 13'h0113
`define SCS_ADDR_CPS 13'h0199
`define SCS_ADDR_PROF0 13'h0F00
`define SCS_ADDR_PROF1 13'h0F01
`define SCS_ADDR_PROF2 13'h0F02
`define SCS_ADDR_PROF3 13'h0F03

`define SCS_RST_SETUP 8'h18
`define SCS_RST_GRADE 8'h00
`define SCS_RST_IDX2 8'h0F
`define SCS_RST_IDX1 8'h3F
`define SCS_RST_MODES 8'h01
`define SCS_RST_LPF 8'h18
`define SCS_RST_GAIN 8'h06
`define SCS_RST_FMT 8'h00
`define SCS_RST_SER 8'h05
`define SCS_RST_ZERO 8'h00

`define SCS_SETUP_LSB_HI 6
`define SCS_SETUP_LSB_LO 1
`define SCS_SETUP_SRST_HI 5
`define SCS_SETUP_SRST_LO 2
`define SCS_SETUP_ONES 8'h18
`define SCS_TRIG_BIT 5
`define SCS_TUNE_BIT 6
`define SCS_CPS_AUTO_BIT 7
`define SCS_HPF_BYP_BIT 7
`define SCS_MODE_FIELD 2:0
`define SCS_MODE_RUN 3'h0

`define SCS_CLK_MHZ 100
`define SCS_WAKE_US 375
`define SCS_WAKE_CYC (`SCS_WAKE_US * `SCS_CLK_MHZ)
// 512 adc clocks, sized to the tune counter
`define SCS_TUNE_ADC_CYC 10'h200
`define SCS_GRADE_FIELD 5:4

`endif

/* File: rtl/scs_sync.v */
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser; first stage is read only by the second
module scs_sync (
    input wire i_clk_sys,
    input wire i_rst,
    input wire i_async,
    output reg o_sync
);
    reg meta;
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            meta <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule
`default_nettype wire

/* File: tb/scs_startup_config_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module scs_startup_config_sva #(
    parameter int WAKE_CYC = 37500
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_csb_n,
    input wire logic i_transmit_trigger,
    input wire logic o_power_down,
    input wire logic o_running,
    input wire logic o_ready,
    input wire logic o_tune_busy,
    input wire logic o_lsb_first,
    input wire logic [7:0] o_gain,
    input wire logic [7:0] o_serial_out,
    input wire logic [7:0] o_lpf
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    int awake = 0;
    int busy_len = 0;
    // both counters saturate past the figure they guard, so they never wrap
    always @(posedge i_clk_sys) begin
        if (i_rst || o_power_down) awake <= 0;
        else if (awake < WAKE_CYC + 8) awake <= awake + 1;
        if (!o_tune_busy) busy_len <= 0;
        else if (busy_len < 4000) busy_len <= busy_len + 1;
    end
    ////////////////////////////////////////////////////////////////
    rst_defaults_a: assert property ($fell(i_rst) |-> o_power_down && !o_running
        && !o_ready && o_gain == 8'h06 && o_serial_out == 8'h05 && o_lpf == 8'h18)
        else $error("reset values wrong");
    pd_frame_a: assert property ($fell(o_power_down) |-> !i_csb_n)
        else $error("power-down left outside a frame");
    ready_early_a: assert property (o_ready |-> awake >= WAKE_CYC - 2)
        else $error("ready before wake time");
    ready_late_a: assert property (awake == WAKE_CYC + 4 |-> o_ready)
        else $error("ready missing after wake time");
    tune_hold_a: assert property ($rose(o_tune_busy) |-> o_tune_busy [*8])
        else $error("tune ended at once");
    tune_min_a: assert property ($fell(o_tune_busy) |-> $past(busy_len) >= 1000)
        else $error("tune shorter than 512 adc clocks");
    hw_trig_a: assert property ($rose(i_transmit_trigger) |-> ##[1:6] o_running)
        else $error("hardware trigger did not start");
    cfg_frame_a: assert property (($changed(o_gain) || $changed(o_lpf)
        || $changed(o_serial_out) || $changed(o_lsb_first)) |-> !$past(i_csb_n, 2))
        else $error("config changed outside a frame");
    cover property ($rose(o_ready));
    cover property ($fell(o_tune_busy));
    cover property ($rose(o_running));
endmodule
bind scs_startup_config scs_startup_config_sva #(.WAKE_CYC(WAKE_CYC)) scs_startup_config_sva_i (.*);
`default_nettype wire

/* File: tb/scs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// serial host; sclk idles low between frames, one byte per frame
module scs_host_model (
    input wire logic i_dev_sdio,
    input wire logic i_dev_oe,
    output var logic o_sclk,
    output var logic o_csb_n,
    output wire logic o_sdio
);
    logic drv, dat, lsb;
    // a released line shows the inverse of its last level, so stale data cannot pass
    assign o_sdio = i_dev_oe ? i_dev_sdio : (drv ? dat : !dat);
    initial begin
        {o_sclk, o_csb_n, drv, dat, lsb} = 5'b01100;
    end
    task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd,
                        output logic [7:0] q);
        logic [23:0] bits;
        int i;
        bits = {rd, 2'b11, a, wd};
        q = 8'h00;
        o_csb_n = 1'b0;
        for (i = 23; i >= 0; i--) begin
            dat = (i < 8 && lsb) ? wd[7 - i] : bits[i];
            drv = !(rd && i < 8);
            #62.5 o_sclk = 1'b1;
            if (i < 8) q[lsb ? 7 - i : i] = o_sdio;
            #62.5 o_sclk = 1'b0;
        end
        drv = 1'b1;
        o_csb_n = 1'b1;
        #250;
    endtask
endmodule
`default_nettype wire

/* File: tb/scs_startup_config_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module scs_startup_config_tb_top;
    localparam int WAKE = 60;
    logic i_clk_sys, i_rst, i_sclk, i_csb_n, i_sdio, i_transmit_trigger, i_adc_clk;
    logic o_sdio, o_sdio_oe, o_power_down, o_running, o_ready, o_tune_busy, o_lsb_first;
    logic o_hpf_bypass, o_cps_auto, o_continuous_run;
    logic [7:0] o_gain, o_serial_out, o_lpf, q;
    logic [12:0] sa [10] = '{13'h004, 13'h005, 13'h113, 13'h011, 13'hF00, 13'hF01,
        13'hF02, 13'hF03, 13'h10C, 13'h014};
    logic [7:0] sd [10] = '{8'h0F, 8'h3F, 8'h00, 8'h06, 8'hFF, 8'h7F, 8'h00, 8'h80, 8'h00, 8'h00};
    int mismatches = 0;
    int n_checks = 0;
    int i, n;
    scs_startup_config #(.WAKE_CYC(WAKE)) scs_startup_config_i (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_sclk(i_sclk),
        .i_csb_n(i_csb_n),
        .i_sdio(i_sdio),
        .i_transmit_trigger(i_transmit_trigger),
        .i_adc_clk(i_adc_clk),
        .o_sdio(o_sdio),
        .o_sdio_oe(o_sdio_oe),
        .o_power_down(o_power_down),
        .o_running(o_running),
        .o_ready(o_ready),
        .o_tune_busy(o_tune_busy),
        .o_lsb_first(o_lsb_first),
        .o_hpf_bypass(o_hpf_bypass),
        .o_cps_auto(o_cps_auto),
        .o_continuous_run(o_continuous_run),
        .o_gain(o_gain),
        .o_serial_out(o_serial_out),
        .o_lpf(o_lpf)
    );
    scs_host_model scs_host_model_i (.i_dev_sdio(o_sdio), .i_dev_oe(o_sdio_oe),
        .o_sclk(i_sclk), .o_csb_n(i_csb_n), .o_sdio(i_sdio));
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = !i_clk_sys;
    end
    initial begin
        i_adc_clk = 1'b0;
        // offset keeps adc edges off the system clock edges
        #2;
        forever #15 i_adc_clk = !i_adc_clk;
    end
    // about three times the expected run
    initial begin
        #300us;
        mismatches++;
        print_verdict();
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp, input string what);
        chk8({7'h00, got}, {7'h00, exp}, what);
    endtask
    // frames start 1 ns past a falling edge so no link edge meets a rising clock edge
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        #1;
        scs_host_model_i.xfer(1'b0, a, d, q);
    endtask
    task automatic rdr(input logic [12:0] a, input logic [7:0] exp, input string what);
        @(negedge i_clk_sys);
        #1;
        scs_host_model_i.xfer(1'b1, a, 8'h00, q);
        chk8(q, exp, what);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        i_rst = 1'b1;
        i_transmit_trigger = 1'b0;
        repeat (16) @(negedge i_clk_sys);
        i_rst = 1'b0;
        repeat (4) @(negedge i_clk_sys);
        chk1(o_power_down, 1'b1, "pd");
        chk8({o_running, o_ready, o_tune_busy, o_continuous_run, 4'h0}, 8'h00, "flg");
        chk8(o_gain, 8'h06, "gain");
        chk8(o_serial_out, 8'h05, "ser");
        chk8(o_lpf, 8'h18, "lpf");
        rdr(13'h000, 8'h18, "setup");
        rdr(13'h1A0, 8'h00, "unmapped");
        chk1(o_sdio_oe, 1'b0, "oe idle");
        $display("reset test done");
        wr(13'h000, 8'h3C);
        rdr(13'h000, 8'h18, "self clear");
        wr(13'h011, 8'h0A);
        wr(13'h002, 8'h00);
        chk8(o_gain, 8'h0A, "gain wr");
        wr(13'h0FF, 8'h01);
        chk8(o_gain, 8'h06, "update");
        for (i = 0; i < 9; i++) wr(sa[i], sd[i]);
        chk1(o_continuous_run, 1'b0, "not taken");
        wr(sa[9], sd[9]);
        chk1(o_continuous_run, 1'b1, "cont");
        chk1(o_hpf_bypass, 1'b1, "hpf");
        rdr(13'h014, 8'h00, "fmt");
        wr(13'h008, 8'h00);
        chk1(o_power_down, 1'b0, "pd off");
        chk1(o_ready, 1'b0, "early");
        repeat (40) @(negedge i_clk_sys);
        chk1(o_ready, 1'b1, "ready");
        wr(13'h199, 8'h80);
        chk1(o_cps_auto, 1'b1, "cps");
        wr(13'h10C, 8'h20);
        chk1(o_running, 1'b1, "sw trig");
        wr(13'h02B, 8'h40);
        chk1(o_tune_busy, 1'b1, "tune");
        n = 0;
        while (o_tune_busy === 1'b1 && n < 3000) begin
            @(negedge i_clk_sys);
            n++;
        end
        // 512 adc periods of 3 cycles, less what passed inside the frame
        chk1(n > 1470 && n < 1540, 1'b1, "tune len");
        $display("startup test done");
        wr(13'h011, 8'h0A);
        wr(13'h000, 8'h24);
        chk8(o_gain, 8'h06, "srst gain");
        chk1(o_running, 1'b0, "srst run");
        chk1(o_power_down, 1'b1, "srst pd");
        wr(13'h011, 8'h0A);
        wr(13'h0FF, 8'h01);
        chk8(o_gain, 8'h0A, "update refused");
        @(negedge i_clk_sys);
        i_transmit_trigger = 1'b1;
        repeat (8) @(negedge i_clk_sys);
        chk1(o_running, 1'b1, "hw trig");
        i_transmit_trigger = 1'b0;
        $display("soft reset test done");
        wr(13'h000, 8'h42);
        chk1(o_lsb_first, 1'b1, "lsb");
        scs_host_model_i.lsb = 1'b1;
        rdr(13'h000, 8'h5A, "mirror");
        wr(13'h011, 8'h0C);
        chk8(o_gain, 8'h0C, "lsb gain");
        wr(13'h000, 8'h18);
        scs_host_model_i.lsb = 1'b0;
        chk1(o_lsb_first, 1'b0, "msb");
        $display("bit order test done");
        print_verdict();
    end
endmodule
`default_nettype wire
